// ---- smrc_consts.vh ----
// constants for the scope remote command subset
`ifndef SMRC_CONSTS_VH
`define SMRC_CONSTS_VH

// command opcodes on the tokenised command port
`define SMRC_OP_LOCK_SET 3'h0
`define SMRC_OP_PAIR_SET 3'h1
`define SMRC_OP_LOCK_QRY 3'h2
`define SMRC_OP_PAIR_QRY 3'h3
`define SMRC_OP_SHIFT_SET 3'h4
`define SMRC_OP_SHIFT_QRY 3'h5
`define SMRC_OP_OPC_SET 3'h6
`define SMRC_OP_OPC_QRY 3'h7

// mode argument tokens
`define SMRC_MODE_ON 2'h1
`define SMRC_MODE_OFF 2'h2

// unit suffix tokens
`define SMRC_UNIT_NONE 2'h0
`define SMRC_UNIT_VOLT 2'h1

// response kinds
`define SMRC_RESP_LOCK 2'h0
`define SMRC_RESP_SHIFT 2'h1
`define SMRC_RESP_OPC 2'h2

// ascii one returned by the operation-complete query
`define SMRC_ASCII_ONE 16'h0031

// status and event bit positions
`define SMRC_STB_ADJ_BIT 2
`define SMRC_ESR_OPC_BIT 0

// reset values
`define SMRC_LOCK_RST 1'b0
`define SMRC_SHIFT_RST 16'h0000

// sensitivity thresholds in millivolts
`define SMRC_SENS_2V 12'h07D0
`define SMRC_SENS_1V 12'h03E8
`define SMRC_SENS_20MV 12'h0014
`define SMRC_SENS_10MV 12'h000A
`define SMRC_SENS_5MV 12'h0005
`define SMRC_SENS_2MV 12'h0002

// shift multiples of the fixed sensitivity
`define SMRC_MUL_LO_2V 8'h06
`define SMRC_MUL_LO_MID 8'h0C
`define SMRC_MUL_LO_5MV 8'h18
`define SMRC_MUL_LO_2MV 8'h3C
`define SMRC_MUL_LO_1MV 8'h78
`define SMRC_MUL_HI_1V 8'h0A
`define SMRC_MUL_HI_MID 8'h0C
`define SMRC_MUL_HI_10MV 8'h18
`define SMRC_MUL_HI_5MV 8'h30

// absolute shift window in millivolts
`define SMRC_SHIFT_ABS_MAX 20'h0_2EE0

`endif

// ---- smrc_clamp.v ----
// shift range limiter for one channel
`timescale 1ns/1ps
`default_nettype none
module smrc_clamp (
   input wire model_low_in,
   input wire [11:0] sens_mv_in,
   input wire signed [15:0] value_in,
   output reg signed [15:0] value_out,
   output reg clamped_out
);
`include "smrc_consts.vh"
   reg [7:0] mult;
   reg [19:0] prod;
   reg [19:0] limit;
   reg signed [19:0] v;
   reg signed [19:0] lim_s;
   always @* begin
      // multiple depends on model class and fixed sensitivity
      if (model_low_in) begin
         if (sens_mv_in >= `SMRC_SENS_2V) mult = `SMRC_MUL_LO_2V;
         else if (sens_mv_in >= `SMRC_SENS_10MV) mult = `SMRC_MUL_LO_MID;
         else if (sens_mv_in >= `SMRC_SENS_5MV) mult = `SMRC_MUL_LO_5MV;
         else if (sens_mv_in >= `SMRC_SENS_2MV) mult = `SMRC_MUL_LO_2MV;
         else mult = `SMRC_MUL_LO_1MV;
      end else begin
         if (sens_mv_in >= `SMRC_SENS_1V) mult = `SMRC_MUL_HI_1V;
         else if (sens_mv_in >= `SMRC_SENS_20MV) mult = `SMRC_MUL_HI_MID;
         else if (sens_mv_in >= `SMRC_SENS_10MV) mult = `SMRC_MUL_HI_10MV;
         else mult = `SMRC_MUL_HI_5MV;
      end
      // no probe factor enters the limit
      prod = mult * sens_mv_in;
      // never beyond the widest window any setting allows
      if (prod > `SMRC_SHIFT_ABS_MAX) limit = `SMRC_SHIFT_ABS_MAX;
      else limit = prod;
      lim_s = $signed(limit);
      v = {{4{value_in[15]}}, value_in};
      clamped_out = 1'b0;
      value_out = value_in;
      if (v > lim_s) begin
         value_out = lim_s[15:0];
         clamped_out = 1'b1;
      end else if (v < -lim_s) begin
         value_out = 16'sh0000 - lim_s[15:0];
         clamped_out = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- smrc_core.v ----
// command interpreter for expand lock, vertical shift and op-complete
// What this block does
// - lock on: horizontal adjustments hit all expanded
// - lock takes only on or off; query reports
// - paired-expand lock command behaves identically
// - channel selector; three and four need quad
// - shift limited to model-dependent sensitivity multiple
// - out of range: nearest value, flag bit two
// - no probe attenuation in shift
// - shift query returns channel's applied shift
// - volt suffix optional, same meaning
// - op-complete sets event bit zero only
// - next command parsed after previous completes
// - op-complete query answers ascii one, in order
// - op-complete works in local or remote
`timescale 1ns/1ps
`default_nettype none
module smrc_core (
   input wire clk_in,
   input wire nrst_in,
   input wire cmd_valid_in,
   output wire cmd_ready_out,
   input wire [2:0] cmd_op_in,
   input wire [1:0] cmd_chan_in,
   input wire [1:0] cmd_mode_in,
   input wire signed [15:0] cmd_value_in,
   input wire [1:0] cmd_unit_in,
   input wire four_chan_in,
   input wire model_low_in,
   input wire [47:0] sens_mv_in,
   input wire [3:0] expanded_in,
   input wire [1:0] sel_trace_in,
   input wire hor_adj_valid_in,
   input wire stb_clear_in,
   output wire [3:0] hor_adj_mask_out,
   output reg multi_expand_lock,
   output reg [63:0] shift_out,
   output reg value_adjusted_flag,
   output reg esr_opc_set_out,
   output reg cmd_error_out,
   output wire resp_valid_out,
   input wire resp_ready_in,
   output reg [1:0] resp_kind_out,
   output reg [1:0] resp_chan_out,
   output reg [15:0] resp_data_out
);
`include "smrc_consts.vh"
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_EXEC = 3'b010;
   localparam [2:0] ST_RESP = 3'b100;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [2:0] op;
   reg [1:0] chan;
   reg [1:0] mode;
   reg signed [15:0] value;
   reg [1:0] unit;
   reg [11:0] sens_sel;
   reg signed [15:0] cur_shift;
   wire signed [15:0] clamp_value;
   wire clamp_hit;
   wire chan_ok;
   wire unit_ok;
   wire adj_set;

   // commands are taken only in idle, so parsing is strictly sequential
   assign cmd_ready_out = state[0];
   assign resp_valid_out = state[2];

   // expanded traces move together under the lock
   assign hor_adj_mask_out = !hor_adj_valid_in ? 4'h0 :
      multi_expand_lock ? expanded_in :
      (4'h1 << sel_trace_in);

   assign chan_ok = four_chan_in || !chan[1];
   // suffix carries no scale: value is always in millivolts
   assign unit_ok = (unit == `SMRC_UNIT_NONE) ||
      (unit == `SMRC_UNIT_VOLT);

   always @* begin
      case (chan)
         2'h0: begin
            sens_sel = sens_mv_in[11:0];
            cur_shift = shift_out[15:0];
         end
         2'h1: begin
            sens_sel = sens_mv_in[23:12];
            cur_shift = shift_out[31:16];
         end
         2'h2: begin
            sens_sel = sens_mv_in[35:24];
            cur_shift = shift_out[47:32];
         end
         default: begin
            sens_sel = sens_mv_in[47:36];
            cur_shift = shift_out[63:48];
         end
      endcase
   end

   smrc_clamp u_clamp (
      .model_low_in(model_low_in),
      .sens_mv_in(sens_sel),
      .value_in(value),
      .value_out(clamp_value),
      .clamped_out(clamp_hit)
   );

   assign adj_set = state[1] && op == `SMRC_OP_SHIFT_SET &&
      chan_ok && unit_ok && clamp_hit;

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (cmd_valid_in) next_state = ST_EXEC;
         end
         ST_EXEC: begin
            // queries answer only after the state is settled
            if ((op == `SMRC_OP_LOCK_QRY) || (op == `SMRC_OP_PAIR_QRY) ||
               (op == `SMRC_OP_OPC_QRY) ||
               (op == `SMRC_OP_SHIFT_QRY && chan_ok)) begin
               next_state = ST_RESP;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_RESP: begin
            if (resp_ready_in) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
         op <= 3'h0;
         chan <= 2'h0;
         mode <= 2'h0;
         value <= 16'sh0000;
         unit <= 2'h0;
         multi_expand_lock <= `SMRC_LOCK_RST;
         shift_out <= {4{`SMRC_SHIFT_RST}};
         value_adjusted_flag <= 1'b0;
         esr_opc_set_out <= 1'b0;
         cmd_error_out <= 1'b0;
         resp_kind_out <= 2'h0;
         resp_chan_out <= 2'h0;
         resp_data_out <= 16'h0000;
      end else begin
         state <= next_state;
         esr_opc_set_out <= 1'b0;
         cmd_error_out <= 1'b0;
         if (state[0] && cmd_valid_in) begin
            op <= cmd_op_in;
            chan <= cmd_chan_in;
            mode <= cmd_mode_in;
            value <= cmd_value_in;
            unit <= cmd_unit_in;
         end
         // a new clamp wins over a clear in the same cycle
         if (adj_set) value_adjusted_flag <= 1'b1;
         else if (stb_clear_in) value_adjusted_flag <= 1'b0;
         // local or remote mode is not consulted anywhere below
         if (state[1]) begin
            case (op)
               `SMRC_OP_LOCK_SET, `SMRC_OP_PAIR_SET: begin
                  if (mode == `SMRC_MODE_ON) begin
                     multi_expand_lock <= 1'b1;
                  end else if (mode == `SMRC_MODE_OFF) begin
                     multi_expand_lock <= 1'b0;
                  end else begin
                     cmd_error_out <= 1'b1;
                  end
               end
               `SMRC_OP_LOCK_QRY, `SMRC_OP_PAIR_QRY: begin
                  resp_kind_out <= `SMRC_RESP_LOCK;
                  resp_chan_out <= 2'h0;
                  resp_data_out <= {15'h0000, multi_expand_lock};
               end
               `SMRC_OP_SHIFT_SET: begin
                  if (!chan_ok || !unit_ok) begin
                     cmd_error_out <= 1'b1;
                  end else begin
                     case (chan)
                        2'h0: shift_out[15:0] <= clamp_value;
                        2'h1: shift_out[31:16] <= clamp_value;
                        2'h2: shift_out[47:32] <= clamp_value;
                        default: shift_out[63:48] <= clamp_value;
                     endcase
                  end
               end
               `SMRC_OP_SHIFT_QRY: begin
                  if (!chan_ok) begin
                     cmd_error_out <= 1'b1;
                  end else begin
                     resp_kind_out <= `SMRC_RESP_SHIFT;
                     resp_chan_out <= chan;
                     resp_data_out <= cur_shift;
                  end
               end
               `SMRC_OP_OPC_SET: begin
                  esr_opc_set_out <= 1'b1;
               end
               default: begin
                  resp_kind_out <= `SMRC_RESP_OPC;
                  resp_chan_out <= 2'h0;
                  resp_data_out <= `SMRC_ASCII_ONE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- smrc_core_properties.sv ----
// assertions on the command interpreter ports
`timescale 1ns/1ps
`default_nettype none
module smrc_core_props (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_ready_out,
   input wire logic [2:0] cmd_op_in,
   input wire logic [1:0] cmd_chan_in,
   input wire logic four_chan_in,
   input wire logic [3:0] expanded_in,
   input wire logic hor_adj_valid_in,
   input wire logic [3:0] hor_adj_mask_out,
   input wire logic multi_expand_lock,
   input wire logic value_adjusted_flag,
   input wire logic stb_clear_in,
   input wire logic esr_opc_set_out,
   input wire logic cmd_error_out,
   input wire logic resp_valid_out,
   input wire logic resp_ready_in,
   input wire logic [15:0] resp_data_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_take;
      cmd_valid_in && cmd_ready_out;
   endsequence
   sequence s_opc_answer;
      ##[1:3] resp_valid_out && resp_data_out == 16'h0031;
   endsequence
   property p_serial;
      s_take |=> !cmd_ready_out;
   endproperty
   a_serial: assert property (p_serial) else $error("ready after take");
   property p_opc_qry;
      s_take ##0 cmd_op_in == 3'h7 |-> s_opc_answer;
   endproperty
   a_opc_qry: assert property (p_opc_qry) else $error("bad opc answer");
   property p_opc_set;
      s_take ##0 cmd_op_in == 3'h6 |-> ##[1:3] esr_opc_set_out;
   endproperty
   a_opc_set: assert property (p_opc_set) else $error("no opc event");
   property p_fanout;
      hor_adj_valid_in && multi_expand_lock |-> hor_adj_mask_out == expanded_in;
   endproperty
   a_fanout: assert property (p_fanout) else $error("mask not all");
   property p_lock_qry;
      s_take ##0 cmd_op_in[2:1] == 2'b01 |->
         ##[1:3] resp_valid_out && resp_data_out == {15'h0000, multi_expand_lock};
   endproperty
   a_lock_qry: assert property (p_lock_qry) else $error("lock answer");
   property p_quad;
      s_take ##0 cmd_op_in[2:1] == 2'b10 && cmd_chan_in[1] && !four_chan_in
         |-> ##[1:3] cmd_error_out;
   endproperty
   a_quad: assert property (p_quad) else $error("channel not refused");
   property p_sticky;
      value_adjusted_flag && !stb_clear_in |=> value_adjusted_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost");
   property p_resp_hold;
      resp_valid_out && !resp_ready_in |=> resp_valid_out && $stable(resp_data_out);
   endproperty
   a_resp_hold: assert property (p_resp_hold) else $error("answer moved");
endmodule
bind smrc_core smrc_core_props u_smrc_core_props (.*);
`default_nettype wire

// ---- smrc_host_model.sv ----
// host side: takes answers after a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module smrc_host_model (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic resp_valid_in,
   input wire logic [3:0] delay_in,
   output logic resp_ready_out
);
   logic [3:0] wait_cnt;
   // a slow host stretches the answer, so later commands must wait
   always @(posedge clk_in) begin
      if (!nrst_in || !resp_valid_in || resp_ready_out) begin
         wait_cnt <= 4'h0;
         resp_ready_out <= 1'b0;
      end else if (wait_cnt >= delay_in) begin
         resp_ready_out <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ---- smrc_core_tb.sv ----
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "smrc_consts.vh"
module smrc_core_tb;
   logic clk_in, nrst_in, cmd_valid_in, four_chan_in, model_low_in;
   logic hor_adj_valid_in, stb_clear_in, resp_ready_in, cmd_ready_out;
   logic multi_expand_lock, value_adjusted_flag, esr_opc_set_out;
   logic cmd_error_out, resp_valid_out;
   logic [2:0] cmd_op_in;
   logic [1:0] cmd_chan_in, cmd_mode_in, cmd_unit_in, sel_trace_in, gch;
   logic [1:0] resp_kind_out, resp_chan_out;
   logic signed [15:0] cmd_value_in;
   logic [15:0] resp_data_out;
   logic [17:0] got;
   logic [47:0] sens_mv_in;
   logic [3:0] expanded_in, hor_adj_mask_out, delay;
   logic [63:0] shift_out;
   int err_total, cmp_count, n_err, n_opc, e0;
   smrc_core u_smrc_core (.*);
   smrc_host_model u_smrc_host_model (.clk_in(clk_in), .nrst_in(nrst_in),
      .resp_valid_in(resp_valid_out), .delay_in(delay),
      .resp_ready_out(resp_ready_in));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (cmd_error_out) n_err <= n_err + 1;
      if (esr_opc_set_out) n_opc <= n_opc + 1;
   end
   task automatic chk(input string what, input logic [63:0] exp, act);
      cmp_count++;
      if (act !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, act);
      end
   endtask
   task automatic cmd(input logic [2:0] op, input logic [1:0] ch, md, u,
      input logic [15:0] v);
      @(posedge clk_in);
      {cmd_valid_in, cmd_op_in, cmd_chan_in, cmd_mode_in, cmd_unit_in,
         cmd_value_in} <= {1'b1, op, ch, md, u, v};
      do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
      cmd_valid_in <= 1'b0;
      repeat (20) begin
         @(negedge clk_in);
         if (resp_valid_out && resp_ready_in) got = {resp_kind_out, resp_data_out};
         if (resp_valid_out && resp_ready_in) gch = resp_chan_out;
         if (cmd_ready_out && !resp_valid_out) break;
      end
      repeat (2) @(negedge clk_in);
   endtask
   task automatic t_lock;
      @(posedge clk_in);
      {expanded_in, sel_trace_in, hor_adj_valid_in} <= {4'hA, 2'h0, 1'b1};
      cmd(`SMRC_OP_LOCK_SET, 2'h0, `SMRC_MODE_ON, 2'h0, 16'h0000);
      chk("lock", 1, multi_expand_lock);
      chk("mask", 4'hA, hor_adj_mask_out);
      cmd(`SMRC_OP_LOCK_QRY, 2'h0, 2'h0, 2'h0, 16'h0000);
      chk("lock answer", 18'h0_0001, got);
      cmd(`SMRC_OP_PAIR_SET, 2'h0, `SMRC_MODE_OFF, 2'h0, 16'h0000);
      chk("lock", 0, multi_expand_lock);
      chk("mask", 4'h1, hor_adj_mask_out);
      @(posedge clk_in);
      hor_adj_valid_in <= 1'b0;
      @(negedge clk_in);
      chk("mask", 4'h0, hor_adj_mask_out);
      cmd(`SMRC_OP_PAIR_QRY, 2'h0, 2'h0, 2'h0, 16'h0000);
      chk("pair answer", 18'h0_0000, got);
      e0 = n_err;
      cmd(`SMRC_OP_LOCK_SET, 2'h0, 2'h3, 2'h0, 16'h0000);
      chk("lock", 0, multi_expand_lock);
      chk("errors", 1, n_err - e0);
      $display("lock test done");
   endtask
   task automatic t_shift;
      @(posedge clk_in);
      {model_low_in, four_chan_in, sens_mv_in} <=
         {2'b11, 12'h005, 12'h3E8, 12'h3E8, 12'h002};
      // host values stay inside the twelve volt window
      cmd(`SMRC_OP_SHIFT_SET, 2'h1, 2'h0, 2'h0, 16'h1388);
      chk("shift1", 16'h1388, shift_out[31:16]);
      chk("flag", 0, value_adjusted_flag);
      cmd(`SMRC_OP_SHIFT_SET, 2'h0, 2'h0, 2'h0, 16'h01F4);
      chk("shift0", 16'h0078, shift_out[15:0]);
      chk("flag", 1, value_adjusted_flag);
      cmd(`SMRC_OP_SHIFT_SET, 2'h0, 2'h0, 2'h0, 16'hFE0C);
      chk("shift0", 16'hFF88, shift_out[15:0]);
      cmd(`SMRC_OP_SHIFT_SET, 2'h2, 2'h0, `SMRC_UNIT_VOLT, 16'h0064);
      chk("shift2", 16'h0064, shift_out[47:32]);
      cmd(`SMRC_OP_SHIFT_QRY, 2'h1, 2'h0, 2'h0, 16'h0000);
      chk("shift answer", 18'h1_1388, got);
      chk("answer chan", 2'h1, gch);
      @(posedge clk_in);
      stb_clear_in <= 1'b1;
      @(posedge clk_in);
      {stb_clear_in, four_chan_in, model_low_in} <= 3'b000;
      @(negedge clk_in);
      chk("flag", 0, value_adjusted_flag);
      e0 = n_err;
      cmd(`SMRC_OP_SHIFT_SET, 2'h3, 2'h0, 2'h0, 16'h012C);
      chk("errors", 1, n_err - e0);
      chk("shift3", 16'h0000, shift_out[63:48]);
      @(posedge clk_in);
      four_chan_in <= 1'b1;
      cmd(`SMRC_OP_SHIFT_SET, 2'h3, 2'h0, 2'h0, 16'h012C);
      chk("shift3", 16'h00F0, shift_out[63:48]);
      cmd(`SMRC_OP_SHIFT_SET, 2'h1, 2'h0, 2'h2, 16'h0064);
      chk("shift1", 16'h1388, shift_out[31:16]);
      $display("shift test done");
   endtask
   task automatic t_opc;
      @(posedge clk_in);
      delay <= 4'h5;
      // 2 mV on the other models allows 96 mV, so 80 mV stays unclamped
      cmd(`SMRC_OP_SHIFT_SET, 2'h0, 2'h0, 2'h0, 16'h0050);
      cmd(`SMRC_OP_OPC_QRY, 2'h0, 2'h0, 2'h0, 16'h0000);
      chk("opc answer", 18'h2_0031, got);
      e0 = n_opc;
      cmd(`SMRC_OP_OPC_SET, 2'h0, 2'h0, 2'h0, 16'h0000);
      chk("opc events", 1, n_opc - e0);
      chk("shift0", 16'h0050, shift_out[15:0]);
      $display("opc test done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {nrst_in, cmd_valid_in, four_chan_in, model_low_in, hor_adj_valid_in,
         stb_clear_in, cmd_op_in, cmd_chan_in, cmd_mode_in, cmd_unit_in,
         sel_trace_in, cmd_value_in, sens_mv_in, expanded_in, delay} = 0;
      repeat (4) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_lock();
      t_shift();
      t_opc();
      conclude();
   end
   initial begin
      repeat (3000) @(posedge clk_in);
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
